// >>> hdgc_pkg.sv
package hdgc_pkg;
  // loop states
  typedef enum logic [1:0] {HDGC_FREE, HDGC_LOCK, HDGC_HOLD} hdgc_state_t;
  // holdover frequency source
  localparam logic [1:0] HOLD_SRC_CENTER = 2'h0;
  localparam logic [1:0] HOLD_SRC_INSTANT = 2'h1;
  localparam logic [1:0] HOLD_SRC_AVERAGE = 2'h2;
  // fractional divider sources
  localparam logic [1:0] FRAC_SRC_PLL = 2'h0;
  localparam logic [1:0] FRAC_SRC_REF_A = 2'h1;
  localparam logic [1:0] FRAC_SRC_REF_B = 2'h2;
  localparam logic [1:0] FRAC_SRC_XTAL = 2'h3;
  // bandwidth codes, 0 = 0.2Hz .. 14 = 6.4kHz; 15 is the fixed synth bandwidth
  localparam logic [3:0] BW_MAX_CODE = 4'hE;
  localparam logic [3:0] BW_SYNTH_CODE = 4'hF;
  localparam logic [31:0] BW_SYNTH_HZ = 32'h00030D40; // 200kHz
  // divider limits
  localparam logic [7:0] INT_DIV_MAX = 8'hA0;
  localparam logic [7:0] INT_DIV_DEFAULT = 8'h04;
  localparam logic [17:0] FRAC_N_MIN = 18'h00004;
  localparam logic [17:0] FRAC_N_INT_MIN = 18'h00003;
  localparam logic [17:0] FRAC_N_DEFAULT = 18'h00004;
  localparam int FRAC_W = 28;
  localparam int FREQ_W = 32;
  // loss-of-signal periods before holdover in gapped mode
  localparam logic [1:0] GAP_LOS_PERIODS = 2'h2;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int HIST_DELAY_MS = 100;
  localparam int HIST_DELAY_CYC = HIST_DELAY_MS * 1000 * CLK_MHZ;
  localparam int IIR_PERIOD_MIN = 20;
  localparam int IIR_SHIFT = 16;
  localparam logic [3:0] GPIO_NUM = 4'h4;
  // gpio modes
  localparam logic [1:0] GP_IN_FIXED = 2'h0;
  localparam logic [1:0] GP_IN_GEN = 2'h1;
  localparam logic [1:0] GP_OUT_FIXED = 2'h2;
  localparam logic [1:0] GP_OUT_GEN = 2'h3;
endpackage

// >>> hdgc_ctrl.sv
`timescale 1ns/100ps
module hdgc_ctrl #(
  parameter int HIST_CYC = hdgc_pkg::HIST_DELAY_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pll_clk_en,
  input wire logic ref_a_edge,
  input wire logic ref_b_edge,
  input wire logic xtal_edge,
  input wire logic ref_a_valid,
  input wire logic ref_b_valid,
  input wire logic ref_a_sel,
  input wire logic ref_a_soft_alarm,
  input wire logic ref_b_soft_alarm,
  input wire logic gapped_mode,
  input wire logic pll_locked,
  input wire logic synth_only_sel,
  input wire logic force_free_run,
  input wire logic [1:0] hold_src_sel,
  input wire logic [hdgc_pkg::FREQ_W-1:0] loop_freq,
  input wire logic [hdgc_pkg::FREQ_W-1:0] band_center,
  input wire logic hold_alarm_clr,
  input wire logic acq_bw_en,
  input wire logic [3:0] acq_bw_code,
  input wire logic [3:0] lock_bw_code,
  input wire logic [7:0] int_div_a,
  input wire logic [7:0] int_div_b,
  input wire logic [7:0] int_div_c,
  input wire logic [17:0] frac_n,
  input wire logic [27:0] frac_f,
  input wire logic [1:0] frac_src_sel,
  input wire logic switch_phase_policy,
  input wire logic ext_loopback,
  input wire logic [1:0] phase_slope_rate,
  input wire logic [15:0] phase_target,
  input wire logic cmos_mode,
  input wire logic cmos_invert,
  input wire logic [3:0] out_enable,
  input wire logic [3:0] out_pwr_dn,
  input wire logic [1:0] in_pwr_dn,
  input wire logic loop_pwr_dn,
  input wire logic cfg_loaded,
  input wire logic [7:0] gpio_mode,
  input wire logic [3:0] gpio_wr_val,
  input wire logic [3:0] gpio_pin_in,
  input wire logic loss_of_lock_alarm,
  output logic [3:0] gpio_pin_out,
  output logic [3:0] gpio_pin_oe_n,
  output logic [3:0] gpio_rd_val,
  output hdgc_pkg::hdgc_state_t loop_state,
  output logic loop_adjust,
  output logic [hdgc_pkg::FREQ_W-1:0] hold_freq,
  output logic hold_alarm,
  output logic irq_out_n,
  output logic [3:0] loop_bw_code,
  output logic int_output_a,
  output logic int_output_b,
  output logic int_output_c,
  output logic frac_output,
  output logic complement_pin,
  output logic [15:0] out_phase,
  output logic [1:0] input_lost_alarm,
  output logic [1:0] in_mon_en,
  output logic loop_en
);
  import hdgc_pkg::*;

  // synchronised reset release
  logic rst_s1_ff, rst_s2_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire rstn = rst_s2_ff;

  // loss detection: holdover only once neither input is valid, selected or powered one
  wire sel_valid = ref_a_sel ? ref_a_valid : ref_b_valid;
  wire sel_soft = ref_a_sel ? ref_a_soft_alarm : ref_b_soft_alarm;
  wire any_valid = (ref_a_valid & ~in_pwr_dn[0]) | (ref_b_valid & ~in_pwr_dn[1]);
  wire synth_run = synth_only_sel & force_free_run;
  // a lost flag means two expired monitor periods, so gapped gaps stay tracked
  wire go_hold = ~any_valid & ~sel_valid;

  hdgc_state_t state_ff, nxt_state;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      HDGC_FREE: if (!synth_run && any_valid) nxt_state = HDGC_LOCK;
      HDGC_LOCK: begin
        if (synth_run) nxt_state = HDGC_FREE;
        else if (go_hold) nxt_state = HDGC_HOLD;
      end
      HDGC_HOLD: begin
        if (synth_run) nxt_state = HDGC_FREE;
        else if (any_valid) nxt_state = HDGC_LOCK;
      end
      default: nxt_state = HDGC_FREE;
    endcase
  end
  wire hold_entry = (state_ff != HDGC_HOLD) && (nxt_state == HDGC_HOLD);
  wire state_change = state_ff != nxt_state;

  // frequency history: sampled every HIST_CYC, two slots give a 100ms-old value
  logic [31:0] hist_cnt_ff;
  logic [FREQ_W-1:0] hist_new_ff, hist_old_ff, iir_ff;
  wire hist_tick = hist_cnt_ff == HIST_CYC[31:0] - 32'h1;
  wire [FREQ_W-1:0] iir_step = FREQ_W'(($signed({1'b0, loop_freq}) -
    $signed({1'b0, iir_ff})) >>> IIR_SHIFT);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hist_cnt_ff <= 32'h0;
      hist_new_ff <= 32'h0;
      hist_old_ff <= 32'h0;
      iir_ff <= 32'h0;
    end else if (state_ff == HDGC_LOCK && !sel_soft) begin
      hist_cnt_ff <= hist_tick ? 32'h0 : hist_cnt_ff + 32'h1;
      if (hist_tick) begin
        hist_new_ff <= loop_freq;
        hist_old_ff <= hist_new_ff;
        iir_ff <= iir_ff + iir_step;
      end
    end
  end

  // holdover target by source
  wire [FREQ_W-1:0] hold_target = (hold_src_sel == HOLD_SRC_CENTER) ? band_center :
    (hold_src_sel == HOLD_SRC_INSTANT) ? hist_old_ff : iir_ff;
  wire [FREQ_W-1:0] ramp_step = FREQ_W'(32'h1 << (2 * phase_slope_rate));

  // holdover frequency: latch the target, or latch latest then ramp in average mode
  logic [FREQ_W-1:0] hold_freq_ff, nxt_hold_freq;
  always_comb begin
    nxt_hold_freq = hold_freq_ff;
    if (hold_entry) begin
      nxt_hold_freq = (hold_src_sel == HOLD_SRC_AVERAGE) ? loop_freq : hold_target;
    end else if (state_ff == HDGC_HOLD && hold_src_sel == HOLD_SRC_AVERAGE) begin
      if (hold_freq_ff + ramp_step < hold_target) nxt_hold_freq = hold_freq_ff + ramp_step;
      else if (hold_freq_ff > hold_target + ramp_step) nxt_hold_freq = hold_freq_ff - ramp_step;
      else nxt_hold_freq = hold_target;
    end
  end

  // sticky holdover alarm; entry wins over clear
  logic hold_alarm_ff;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= HDGC_FREE;
      hold_freq_ff <= 32'h0;
      hold_alarm_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      hold_freq_ff <= nxt_hold_freq;
      hold_alarm_ff <= hold_entry | (hold_alarm_ff & ~hold_alarm_clr);
    end
  end

  // bandwidth selection
  wire [3:0] acq_c = (acq_bw_code > BW_MAX_CODE) ? BW_MAX_CODE : acq_bw_code;
  wire [3:0] lock_c = (lock_bw_code > BW_MAX_CODE) ? BW_MAX_CODE : lock_bw_code;
  wire [3:0] nxt_bw = synth_only_sel ? BW_SYNTH_CODE :
    (acq_bw_en && !pll_locked) ? acq_c : lock_c;

  // phase handling on switch events
  logic [15:0] phase_ff, phase_goal_ff;
  logic sel_d_ff;
  wire hitless = ~switch_phase_policy & ~ext_loopback;
  wire [15:0] slew = 16'h1 << phase_slope_rate;
  // reference swap seen against last cycle's selection
  wire phase_evt = state_change | (ref_a_sel != sel_d_ff);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      phase_ff <= 16'h0;
      phase_goal_ff <= 16'h0;
      sel_d_ff <= 1'b0;
    end else begin
      sel_d_ff <= ref_a_sel;
      phase_goal_ff <= (phase_evt && hitless) ? phase_ff : phase_target;
      if (!hitless) begin
        if (phase_ff + slew < phase_goal_ff) phase_ff <= phase_ff + slew;
        else if (phase_ff > phase_goal_ff + slew) phase_ff <= phase_ff - slew;
        else phase_ff <= phase_goal_ff;
      end
    end
  end

  // integer dividers, one per output
  logic [2:0] int_q_ff;
  wire [7:0] div_cfg [3];
  assign div_cfg[0] = int_div_a;
  assign div_cfg[1] = int_div_b;
  assign div_cfg[2] = int_div_c;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_int
      logic [7:0] cnt_ff;
      wire [7:0] d = div_cfg[gi];
      wire ok = (d == 8'h03) || (d == 8'h05) || (!d[0] && d >= 8'h04 && d <= INT_DIV_MAX);
      wire [7:0] dv = ok ? d : INT_DIV_DEFAULT;
      wire wrap = cnt_ff >= dv - 8'h1;
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          cnt_ff <= 8'h0;
          int_q_ff[gi] <= 1'b0;
        end else if (out_pwr_dn[gi]) begin
          cnt_ff <= 8'h0;
          int_q_ff[gi] <= 1'b0;
        end else if (pll_clk_en) begin
          cnt_ff <= wrap ? 8'h0 : cnt_ff + 8'h1;
          int_q_ff[gi] <= cnt_ff < (dv >> 1);
        end
      end
    end
  endgenerate

  // fractional divider: period 2*N.F half-periods of N, accumulator adds one
  wire frac_in = (frac_src_sel == FRAC_SRC_PLL) ? pll_clk_en :
    (frac_src_sel == FRAC_SRC_REF_A) ? ref_a_edge :
    (frac_src_sel == FRAC_SRC_REF_B) ? ref_b_edge : xtal_edge;
  wire n_ok = (frac_n >= FRAC_N_MIN) || (frac_n == FRAC_N_INT_MIN && frac_f == 28'h0);
  wire [17:0] n_use = n_ok ? frac_n : FRAC_N_DEFAULT;
  logic [17:0] fcnt_ff;
  logic [FRAC_W-1:0] acc_ff;
  logic extra_ff, fq_ff;
  wire [FRAC_W:0] acc_sum = {1'b0, acc_ff} + {1'b0, frac_f};
  wire [17:0] half_len = extra_ff ? n_use : n_use - 18'h1;
  wire half_end = fcnt_ff >= half_len;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fcnt_ff <= 18'h0;
      acc_ff <= 28'h0;
      extra_ff <= 1'b0;
      fq_ff <= 1'b0;
    end else if (out_pwr_dn[3]) begin
      fcnt_ff <= 18'h0;
      fq_ff <= 1'b0;
    end else if (frac_in) begin
      fcnt_ff <= half_end ? 18'h0 : fcnt_ff + 18'h1;
      if (half_end) begin
        fq_ff <= ~fq_ff;
        if (fq_ff) begin
          acc_ff <= acc_sum[FRAC_W-1:0];
          extra_ff <= acc_sum[FRAC_W];
        end
      end
    end
  end

  // gpio decode; fixed functions mirror status each cycle
  wire [3:0] fixed_st = {loss_of_lock_alarm, ~ref_a_valid, ~ref_b_valid, hold_alarm_ff};
  logic [3:0] gp_out_ff, gp_oe_n_ff, gp_rd_ff;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_gp
      wire [1:0] m = cfg_loaded ? gpio_mode[2*gi +: 2] : GP_IN_FIXED;
      wire is_out = m[1];
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          gp_out_ff[gi] <= 1'b0;
          gp_oe_n_ff[gi] <= 1'b1;
          gp_rd_ff[gi] <= 1'b0;
        end else begin
          gp_oe_n_ff[gi] <= ~is_out;
          gp_out_ff[gi] <= (m == GP_OUT_FIXED) ? fixed_st[gi] : gpio_wr_val[gi];
          gp_rd_ff[gi] <= gpio_pin_in[gi];
        end
      end
    end
  endgenerate
  // pin 3 has no fixed input function; its enable-map use is elsewhere

  // outputs and power
  logic [3:0] bw_ff;
  logic [2:0] iq_ff;
  logic fo_ff, fc_ff, irq_n_ff;
  logic [1:0] los_ff, mon_ff;
  logic loop_en_ff, adj_ff;
  wire frac_on = out_enable[3] & ~out_pwr_dn[3];
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bw_ff <= 4'h0;
      iq_ff <= 3'h0;
      fo_ff <= 1'b0;
      fc_ff <= 1'b0;
      irq_n_ff <= 1'b1;
      los_ff <= 2'h0;
      mon_ff <= 2'h0;
      loop_en_ff <= 1'b0;
      adj_ff <= 1'b0;
    end else begin
      bw_ff <= nxt_bw;
      iq_ff <= int_q_ff & out_enable[2:0] & ~out_pwr_dn[2:0];
      fo_ff <= frac_on & fq_ff;
      // shared enable; cmos pair in-phase or inverted, else differential
      fc_ff <= frac_on & (cmos_mode ? (fq_ff ^ cmos_invert) : ~fq_ff);
      irq_n_ff <= ~hold_alarm_ff;
      los_ff <= {~ref_b_valid, ~ref_a_valid};
      mon_ff <= ~in_pwr_dn;
      loop_en_ff <= ~(loop_pwr_dn & synth_only_sel);
      adj_ff <= (state_ff == HDGC_LOCK) & ~sel_soft;
    end
  end

  assign gpio_pin_out = gp_out_ff;
  assign gpio_pin_oe_n = gp_oe_n_ff;
  assign gpio_rd_val = gp_rd_ff;
  assign loop_state = state_ff;
  assign loop_adjust = adj_ff;
  assign hold_freq = hold_freq_ff;
  assign hold_alarm = hold_alarm_ff;
  assign irq_out_n = irq_n_ff;
  assign loop_bw_code = bw_ff;
  assign int_output_a = iq_ff[0];
  assign int_output_b = iq_ff[1];
  assign int_output_c = iq_ff[2];
  assign frac_output = fo_ff;
  assign complement_pin = fc_ff;
  assign out_phase = phase_ff;
  assign input_lost_alarm = los_ff;
  assign in_mon_en = mon_ff;
  assign loop_en = loop_en_ff;

  // checks
  property p_hold_entry;
    @(posedge sys_clk) disable iff (!rstn)
      (state_ff == HDGC_LOCK && go_hold && !synth_run) |=> state_ff == HDGC_HOLD;
  endproperty
  a_hold_entry: assert property (p_hold_entry) else $error("no holdover");
  property p_alarm;
    @(posedge sys_clk) disable iff (!rstn) hold_entry |=> hold_alarm_ff ##1 !irq_n_ff;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm missing");
  property p_synth_bw;
    @(posedge sys_clk) disable iff (!rstn) synth_only_sel |=> bw_ff == BW_SYNTH_CODE;
  endproperty
  a_synth_bw: assert property (p_synth_bw) else $error("synth bw");
  property p_acq_bw;
    @(posedge sys_clk) disable iff (!rstn)
      (!synth_only_sel && acq_bw_en && !pll_locked && acq_bw_code <= BW_MAX_CODE)
      |=> bw_ff == $past(acq_bw_code);
  endproperty
  a_acq_bw: assert property (p_acq_bw) else $error("acq bw");
  property p_hitless;
    @(posedge sys_clk) disable iff (!rstn) hitless |=> $stable(phase_ff);
  endproperty
  a_hitless: assert property (p_hitless) else $error("phase moved");
  property p_synth_free;
    @(posedge sys_clk) disable iff (!rstn) synth_run |=> state_ff == HDGC_FREE;
  endproperty
  a_synth_free: assert property (p_synth_free) else $error("not free-run");
  property p_gp_default;
    @(posedge sys_clk) disable iff (!rstn) !cfg_loaded |=> gp_oe_n_ff == 4'hF;
  endproperty
  a_gp_default: assert property (p_gp_default) else $error("gpio not input");
  property p_pin3_lol;
    @(posedge sys_clk) disable iff (!rstn)
      (cfg_loaded && gpio_mode[7:6] == GP_OUT_FIXED) |=> gp_out_ff[3] == $past(loss_of_lock_alarm);
  endproperty
  a_pin3_lol: assert property (p_pin3_lol) else $error("pin3 lol");
  c_hold: cover property (@(posedge sys_clk) disable iff (!rstn) hold_entry);
  c_relock: cover property (@(posedge sys_clk) disable iff (!rstn)
    state_ff == HDGC_HOLD ##1 state_ff == HDGC_LOCK);
  c_frac_ovf: cover property (@(posedge sys_clk) disable iff (!rstn) extra_ff);
endmodule

// >>> hdgc_far_end.sv
`timescale 1ns/100ps
// behavioural references and crystal: ref a ticks every 4 cycles, ref b every 8,
// crystal every 2, pll every cycle; validity and soft alarms as the monitor sees them
module hdgc_far_end (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ref_a_on,
  input wire logic ref_b_on,
  output logic pll_clk_en,
  output logic ref_a_edge,
  output logic ref_b_edge,
  output logic xtal_edge,
  output logic ref_a_valid,
  output logic ref_b_valid,
  output logic ref_a_soft_alarm,
  output logic ref_b_soft_alarm
);
  logic [3:0] ph_ff;
  logic [3:0] seen_ff [2];
  logic [3:0] gap_ff [2];
  logic [1:0] tick;
  // edges are launched just after a clock edge, as a real source would be sampled
  assign tick[0] = ref_a_on && ph_ff[1:0] == 2'h0;
  assign tick[1] = ref_b_on && ph_ff[2:0] == 3'h1;
  assign ref_a_edge = tick[0];
  assign ref_b_edge = tick[1];
  assign xtal_edge = ph_ff[0];
  assign pll_clk_en = rst_n;
  assign ref_a_valid = seen_ff[0] == 4'h8;
  assign ref_b_valid = seen_ff[1] == 4'h8;
  assign ref_a_soft_alarm = gap_ff[0] > 4'h5;
  assign ref_b_soft_alarm = gap_ff[1] > 4'h5;
  // eight edges validate an input; a gap of two monitor periods drops it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_ff <= 4'h0;
      for (int i = 0; i < 2; i++) begin
        seen_ff[i] <= 4'h0;
        gap_ff[i] <= 4'hF;
      end
    end else begin
      ph_ff <= ph_ff + 4'h1;
      for (int i = 0; i < 2; i++) begin
        if (tick[i]) begin
          gap_ff[i] <= 4'h0;
          if (seen_ff[i] != 4'h8) seen_ff[i] <= seen_ff[i] + 4'h1;
        end else if (gap_ff[i] != 4'hF) begin
          gap_ff[i] <= gap_ff[i] + 4'h1;
        end
        if (!tick[i] && gap_ff[i] > 4'hB) seen_ff[i] <= 4'h0;
      end
    end
  end
endmodule

// >>> holdover_divider_gpio_ctrl_tb.sv
`timescale 1ns/100ps
module holdover_divider_gpio_ctrl_tb;
  import hdgc_pkg::*;
  logic sys_clk, rst_n, pll_clk_en, ref_a_edge, ref_b_edge, xtal_edge, ref_a_valid, ref_b_valid;
  logic ref_a_on, ref_b_on, ref_a_soft_alarm, ref_b_soft_alarm, msel, ref_a_sel, gapped_mode;
  logic pll_locked, synth_only_sel, force_free_run, hold_alarm_clr, acq_bw_en, loop_en;
  logic switch_phase_policy, ext_loopback, cmos_mode, cmos_invert, loop_pwr_dn, cfg_loaded;
  logic loss_of_lock_alarm, loop_adjust, hold_alarm, irq_out_n, int_output_a, int_output_b;
  logic int_output_c, frac_output, complement_pin;
  logic [1:0] hold_src_sel, frac_src_sel, phase_slope_rate, in_pwr_dn, input_lost_alarm, in_mon_en;
  logic [3:0] acq_bw_code, lock_bw_code, out_enable, out_pwr_dn, gpio_wr_val, gpio_pin_in;
  logic [3:0] gpio_pin_out, gpio_pin_oe_n, gpio_rd_val, loop_bw_code;
  logic [7:0] int_div_a, int_div_b, int_div_c, gpio_mode;
  logic [17:0] frac_n;
  logic [27:0] frac_f;
  logic [15:0] phase_target, out_phase, ph_keep;
  logic [FREQ_W-1:0] loop_freq, band_center, hold_freq;
  hdgc_state_t loop_state;
  logic [31:0] seed;
  int fail_count, cmp_count, p1, p2;
  logic [7:0] dv [5] = '{8'h03, 8'h05, 8'hA0, 8'h07, 8'hA2};
  int dx [5] = '{3, 5, 160, 4, 4};
  logic [17:0] fn [5] = '{18'h5, 18'h3, 18'h2, 18'h4, 18'h4};
  logic [1:0] fs [5] = '{FRAC_SRC_PLL, FRAC_SRC_PLL, FRAC_SRC_PLL, FRAC_SRC_XTAL, FRAC_SRC_REF_A};
  int fx [5] = '{20, 12, 16, 32, 64};
  wire mon = msel ? frac_output : int_output_a;
  hdgc_far_end far_u (.sys_clk, .rst_n, .ref_a_on, .ref_b_on, .pll_clk_en, .ref_a_edge,
    .ref_b_edge, .xtal_edge, .ref_a_valid, .ref_b_valid, .ref_a_soft_alarm, .ref_b_soft_alarm);
  // short history window keeps the instantaneous holdover case brief
  hdgc_ctrl #(.HIST_CYC(16)) dut_u (.sys_clk, .rst_n, .pll_clk_en, .ref_a_edge, .ref_b_edge,
    .xtal_edge, .ref_a_valid, .ref_b_valid, .ref_a_sel, .ref_a_soft_alarm, .ref_b_soft_alarm,
    .gapped_mode, .pll_locked, .synth_only_sel, .force_free_run, .hold_src_sel, .loop_freq,
    .band_center, .hold_alarm_clr, .acq_bw_en, .acq_bw_code, .lock_bw_code, .int_div_a,
    .int_div_b, .int_div_c, .frac_n, .frac_f, .frac_src_sel, .switch_phase_policy, .ext_loopback,
    .phase_slope_rate, .phase_target, .cmos_mode, .cmos_invert, .out_enable, .out_pwr_dn,
    .in_pwr_dn, .loop_pwr_dn, .cfg_loaded, .gpio_mode, .gpio_wr_val, .gpio_pin_in,
    .loss_of_lock_alarm, .gpio_pin_out, .gpio_pin_oe_n, .gpio_rd_val, .loop_state, .loop_adjust,
    .hold_freq, .hold_alarm, .irq_out_n, .loop_bw_code, .int_output_a, .int_output_b,
    .int_output_c, .frac_output, .complement_pin, .out_phase, .input_lost_alarm, .in_mon_en,
    .loop_en);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? (s >> 1) ^ 32'hA3000000 : s >> 1;
  endfunction
  // expected bandwidth code; synth mode overrides, codes above 14 saturate
  function automatic logic [31:0] exp_bw();
    logic [3:0] c;
    c = (acq_bw_en && !pll_locked) ? acq_bw_code : lock_bw_code;
    if (synth_only_sel) return {28'h0, BW_SYNTH_CODE};
    return (c > BW_MAX_CODE) ? {28'h0, BW_MAX_CODE} : {28'h0, c};
  endfunction
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wait_st(input hdgc_state_t s, input int lim);
    for (int n = 0; n < lim; n++) begin
      @(negedge sys_clk);
      if (loop_state === s) begin
        cmp_count++;
        return;
      end
    end
    fail_count++;
    $display("BAD loop_state wait expected %0d seen %0d", s, loop_state);
    conclude();
  endtask
  // cycles between two rising edges of the watched divider output
  task automatic meas(input logic sel, output int per);
    int e;
    logic prev;
    msel = sel;
    per = 0;
    e = 0;
    prev = 1'b1;
    for (int n = 0; n < 3000 && e < 2; n++) begin
      @(negedge sys_clk);
      if (e == 1) per++;
      if (mon && !prev) e++;
      prev = mon;
    end
    if (e < 2) begin
      fail_count++;
      $display("BAD divider edge wait expected 2 seen %0d", e);
      conclude();
    end
  endtask
  task automatic fixed_chk();
    chk("fixed", {28'h0, loss_of_lock_alarm, ~ref_a_valid, ~ref_b_valid, hold_alarm},
      {28'h0, gpio_pin_out});
    chk("los", {30'h0, ~ref_b_valid, ~ref_a_valid}, {30'h0, input_lost_alarm});
  endtask
  initial begin
    {rst_n, ref_a_on, ref_b_on, msel, ref_a_sel, gapped_mode, pll_locked, synth_only_sel} = '0;
    {force_free_run, hold_alarm_clr, acq_bw_en, switch_phase_policy, ext_loopback} = '0;
    {cmos_mode, cmos_invert, loop_pwr_dn, cfg_loaded, loss_of_lock_alarm, hold_src_sel} = '0;
    {loop_freq, band_center, acq_bw_code, lock_bw_code, phase_slope_rate, phase_target} = '0;
    {frac_f, frac_src_sel, out_pwr_dn, in_pwr_dn, gpio_mode, gpio_wr_val, gpio_pin_in} = '0;
    {int_div_a, int_div_b, int_div_c, frac_n, out_enable} = {24'h040404, 18'h4, 4'hF};
    {seed, fail_count, cmp_count} = {32'h00010943, 64'h0};
    cyc(12);
    chk("oe_n_rst", 32'hF, {28'h0, gpio_pin_oe_n});
    chk("irq_rst", 32'h1, {31'h0, irq_out_n});
    rst_n = 1'b1;
    gpio_mode = 8'hFF;
    cyc(4);
    chk("oe_n_unloaded", 32'hF, {28'h0, gpio_pin_oe_n});
    cfg_loaded = 1'b1;
    // alternate general outputs and general inputs with random data
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      {in_pwr_dn, gpio_pin_in, gpio_wr_val} = seed[9:0];
      gpio_mode = i[0] ? 8'h55 : 8'hFF;
      cyc(3);
      if (i[0]) chk("rd_val", {28'h0, gpio_pin_in}, {28'h0, gpio_rd_val});
      else chk("pin_out", {28'h0, gpio_wr_val}, {28'h0, gpio_pin_out});
      chk("oe_n", i[0] ? 32'hF : 32'h0, {28'h0, gpio_pin_oe_n});
      chk("mon_en", {30'h0, ~in_pwr_dn}, {30'h0, in_mon_en});
    end
    // inputs powered again so the holdover rounds can validate both references
    in_pwr_dn = 2'h0;
    $display("test gpio done");
    for (int c = 0; c < 16; c++) begin
      seed = lfsr(seed);
      {pll_locked, acq_bw_en, acq_bw_code} = seed[5:0];
      lock_bw_code = c[3:0];
      synth_only_sel = (c == 7);
      force_free_run = (c == 7);
      cyc(3);
      chk("bw", exp_bw(), {28'h0, loop_bw_code});
    end
    {synth_only_sel, force_free_run, acq_bw_en} = 3'h0;
    $display("test bandwidth done");
    for (int i = 0; i < 5; i++) begin
      {int_div_a, int_div_b, int_div_c} = {3{dv[i]}};
      meas(1'b0, p1);
      meas(1'b0, p1);
      chk("int_div", dx[i], p1);
      chk("int_bc", {30'h0, int_output_a, int_output_a}, {30'h0, int_output_b, int_output_c});
    end
    ref_a_on = 1'b1;
    for (int i = 0; i < 6; i++) begin
      frac_n = (i == 5) ? 18'h4 : fn[i];
      frac_f = (i == 5) ? 28'h8000000 : 28'h0;
      frac_src_sel = (i == 5) ? FRAC_SRC_PLL : fs[i];
      meas(1'b1, p1);
      meas(1'b1, p1);
      meas(1'b1, p2);
      chk("frac_div", (i == 5) ? 18 : fx[i], p1 + p2);
    end
    cmos_mode = 1'b1;
    for (int v = 0; v < 2; v++) begin
      cmos_invert = v[0];
      cyc(3);
      for (int k = 0; k < 8; k++) begin
        cyc(1);
        chk("complement", {31'h0, frac_output ^ cmos_invert}, {31'h0, complement_pin});
      end
    end
    $display("test dividers done");
    // center, instantaneous, then average holdover; slope limiting in the middle round only
    // high loop value keeps the average ramp heading down from the latest offset
    {gpio_mode, pll_locked, ref_a_sel} = {8'hAA, 2'h3};
    {phase_target, phase_slope_rate} = {16'h0040, 2'h2};
    for (int r = 0; r < 3; r++) begin
      seed = lfsr(seed);
      {band_center, loop_freq} = {seed, ~seed | 32'h80000000};
      hold_src_sel = (r == 2) ? HOLD_SRC_AVERAGE : r[0] ? HOLD_SRC_INSTANT : HOLD_SRC_CENTER;
      {switch_phase_policy, loss_of_lock_alarm, ref_a_on, ref_b_on} = {r[0], r[0], 1'b1, r[0]};
      wait_st(HDGC_LOCK, 300);
      cyc(40);
      fixed_chk();
      chk("adjust", 32'h1, {31'h0, loop_adjust});
      if (r == 1) chk("phase_slope", 32'h40, {16'h0, out_phase});
      ph_keep = out_phase;
      {ref_a_on, ref_b_on} = 2'h0;
      wait_st(HDGC_HOLD, 60);
      chk("hold_alarm", 32'h1, {31'h0, hold_alarm});
      chk("hold_entry", (r == 0) ? band_center : loop_freq, hold_freq);
      cyc(1);
      chk("irq", 32'h0, {31'h0, irq_out_n});
      cyc(4);
      // average mode has ramped five steps of sixteen toward the history value
      chk("hold_freq", (r == 2) ? loop_freq - 32'h50 : (r == 1) ? loop_freq : band_center,
        hold_freq);
      chk("adjust_hold", 32'h0, {31'h0, loop_adjust});
      if (r != 1) chk("phase_hitless", {16'h0, ph_keep}, {16'h0, out_phase});
      fixed_chk();
      hold_alarm_clr = 1'b1;
      cyc(1);
      hold_alarm_clr = 1'b0;
      cyc(3);
      chk("irq_clr", 32'h1, {31'h0, irq_out_n});
    end
    $display("test holdover done");
    {synth_only_sel, force_free_run, loop_pwr_dn} = 3'h7;
    wait_st(HDGC_FREE, 20);
    cyc(2);
    chk("bw_synth", 32'hF, {28'h0, loop_bw_code});
    chk("loop_en", 32'h0, {31'h0, loop_en});
    $display("test synth done");
    conclude();
  end
endmodule
